/* ext_mem_model.sv */
// Purpose: Extended memory standing behind the mailbox port.
// Assumes: One access at a time, answered after delay_in idle cycles.
// Notes: Read data is only meaningful with ack; it toggles otherwise.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Extended port
  input wire logic req_in,
  input wire sensor_regs_pkg::ext_request_type cmd_in,
  input wire logic [3:0] delay_in,
  output logic ack_out,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [256];
  logic [3:0] wait_r;
  initial for (int i = 0; i < 256; i++) mem[i] = {16'hC35A, i[7:0], ~i[7:0]};
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= 1'b0;
      wait_r <= 4'h0;
      rdata_out <= 32'h0000_0000;
    end else if (ack_out || !req_in || wait_r < delay_in) begin
      // Ack is a single pulse; the request drops right after it
      ack_out <= 1'b0;
      wait_r <= (ack_out || !req_in) ? 4'h0 : wait_r + 4'h1;
      rdata_out <= ~rdata_out;
    end else begin
      ack_out <= 1'b1;
      rdata_out <= mem[cmd_in.target];
      if (cmd_in.write) mem[cmd_in.target] <= cmd_in.word;
    end
  end
endmodule
`default_nettype wire

/* sensor_direct_register_space.sv */
// Purpose: Direct register space with extended write and read mailboxes and result views.
// Assumes: Register port and result inputs come from logic on clock_in.
// Notes: Extended memory answers on ext_ack_in; one access is in flight at a time.
`timescale 1ns/1ps
`default_nettype none
module sensor_direct_register_space (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [sensor_regs_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [1:0] reg_byte_en_in,
  input wire logic [sensor_regs_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [sensor_regs_pkg::DATA_W-1:0] reg_rdata_out,
  // Mode and sensing results
  input wire logic i2c_mode_in,
  input wire logic results_update_in,
  input wire sensor_regs_pkg::sense_results_type results_in,
  // Extended memory port
  output logic ext_req_out,
  output sensor_regs_pkg::ext_request_type ext_cmd_out,
  output logic ext_shadow_out,
  input wire logic ext_ack_in,
  input wire logic [31:0] ext_rdata_in
);

  typedef enum logic [1:0] {EXT_IDLE, EXT_WRITE, EXT_READ} ext_state_type;

  ext_state_type ext_state_r;
  logic [7:0] wr_target_r;
  logic [7:0] rd_target_r;
  logic [15:0] wr_high_r;
  logic [15:0] wr_low_r;
  logic [31:0] rd_word_r;
  logic wr_busy_r;
  logic wr_done_r;
  logic rd_busy_r;
  logic rd_done_r;
  logic [7:0] echo_select_r;
  logic [15:0] echo_value_r;
  sensor_regs_pkg::sense_results_type res_r;

  logic wr_hit;
  logic wr_launch;
  logic rd_launch;

  // Byte-lane aware update of a 16-bit register
  function automatic logic [15:0] merge_bytes(input logic [15:0] old_val, input logic [1:0] be,
                                              input logic [15:0] new_val);
    logic [15:0] res;
    res = old_val;
    if (be[1]) begin
      res[15:8] = new_val[15:8];
    end
    if (be[0]) begin
      res[7:0] = new_val[7:0];
    end
    return res;
  endfunction

  // Zero-pad a 15-bit field; bit 15 of every padded result word reads zero
  function automatic logic [15:0] pad15(input logic [14:0] v);
    return {1'b0, v};
  endfunction

  function automatic logic [15:0] echo_pick(input logic [7:0] sel, input sensor_regs_pkg::sense_results_type r);
    logic [15:0] v;
    v = 16'h0000;
    case (sel)
      sensor_regs_pkg::ECHO_TEMP: v = {4'h0, r.temp_value};
      sensor_regs_pkg::ECHO_X: v = pad15(r.axis_x_value);
      sensor_regs_pkg::ECHO_Y: v = pad15(r.axis_y_value);
      sensor_regs_pkg::ECHO_Z: v = pad15(r.axis_z_value);
      sensor_regs_pkg::ECHO_ANGLE: v = pad15(r.angle_value);
      sensor_regs_pkg::ECHO_MAG: v = pad15(r.magnitude_value);
      sensor_regs_pkg::ECHO_SINE: v = pad15(r.sine_value);
      sensor_regs_pkg::ECHO_COSINE: v = pad15(r.cosine_value);
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  assign wr_hit = reg_wr_in;
  // Launch only honoured on the high byte lane and while the mailbox is free
  assign wr_launch = wr_hit && reg_addr_in == sensor_regs_pkg::OFS_WR_CTRL && reg_byte_en_in[1]
                     && reg_wdata_in[sensor_regs_pkg::BIT_LAUNCH] && ext_state_r == EXT_IDLE;
  assign rd_launch = wr_hit && reg_addr_in == sensor_regs_pkg::OFS_RD_CTRL && reg_byte_en_in[1]
                     && reg_wdata_in[sensor_regs_pkg::BIT_LAUNCH] && ext_state_r == EXT_IDLE
                     && !wr_launch;

  // Mailbox address and data holding registers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_target_r <= 8'h00;
      rd_target_r <= 8'h00;
      wr_high_r <= 16'h0000;
      wr_low_r <= 16'h0000;
      echo_select_r <= 8'h00;
    end else if (wr_hit) begin
      case (reg_addr_in)
        sensor_regs_pkg::OFS_WR_TARGET: begin
          if (reg_byte_en_in[0]) begin
            wr_target_r <= reg_wdata_in[7:0];
          end
        end
        sensor_regs_pkg::OFS_RD_TARGET: begin
          if (reg_byte_en_in[0]) begin
            rd_target_r <= reg_wdata_in[7:0];
          end
        end
        sensor_regs_pkg::OFS_WR_HIGH: wr_high_r <= merge_bytes(wr_high_r, reg_byte_en_in, reg_wdata_in);
        sensor_regs_pkg::OFS_WR_LOW: wr_low_r <= merge_bytes(wr_low_r, reg_byte_en_in, reg_wdata_in);
        sensor_regs_pkg::OFS_ECHO_SEL: begin
          if (reg_byte_en_in[0]) begin
            echo_select_r <= reg_wdata_in[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Extended access sequencer
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_state_r <= EXT_IDLE;
      ext_req_out <= 1'b0;
      ext_cmd_out <= '0;
      ext_shadow_out <= 1'b0;
    end else begin
      case (ext_state_r)
        EXT_IDLE: begin
          if (wr_launch) begin
            ext_state_r <= EXT_WRITE;
            ext_req_out <= 1'b1;
            ext_cmd_out.write <= 1'b1;
            ext_cmd_out.target <= wr_target_r;
            ext_cmd_out.word <= {wr_high_r, wr_low_r};
            ext_shadow_out <= wr_target_r >= sensor_regs_pkg::SHADOW_OFFSET;
          end else if (rd_launch) begin
            ext_state_r <= EXT_READ;
            ext_req_out <= 1'b1;
            ext_cmd_out.write <= 1'b0;
            ext_cmd_out.target <= rd_target_r;
            ext_shadow_out <= rd_target_r >= sensor_regs_pkg::SHADOW_OFFSET;
          end
        end
        EXT_WRITE, EXT_READ: begin
          if (ext_ack_in) begin
            ext_state_r <= EXT_IDLE;
            ext_req_out <= 1'b0;
          end
        end
        default: begin
          ext_state_r <= EXT_IDLE;
          ext_req_out <= 1'b0;
        end
      endcase
    end
  end

  // Write status flags; a launch cannot meet a finish since launch needs idle
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_busy_r <= 1'b0;
      wr_done_r <= 1'b0;
    end else if (wr_launch) begin
      wr_busy_r <= 1'b1;
      wr_done_r <= 1'b0;
    end else if (ext_state_r == EXT_WRITE && ext_ack_in) begin
      wr_busy_r <= 1'b0;
      wr_done_r <= 1'b1;
    end
  end

  // Read status flags and returned word
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_busy_r <= 1'b0;
      rd_done_r <= 1'b0;
      rd_word_r <= 32'h0000_0000;
    end else if (rd_launch) begin
      rd_busy_r <= 1'b1;
      rd_done_r <= 1'b0;
    end else if (ext_state_r == EXT_READ && ext_ack_in) begin
      rd_word_r <= ext_rdata_in;
      rd_busy_r <= 1'b0;
      rd_done_r <= 1'b1;
    end
  end

  // Result capture; echo follows the selected channel of the newest sample
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      res_r <= '0;
      echo_value_r <= 16'h0000;
    end else if (results_update_in) begin
      res_r <= results_in;
      echo_value_r <= echo_pick(echo_select_r, results_in);
    end
  end

  // Registered read data; unmapped or SPI-hidden words read zero
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        sensor_regs_pkg::OFS_WR_TARGET: reg_rdata_out <= {8'h00, wr_target_r};
        sensor_regs_pkg::OFS_WR_HIGH: reg_rdata_out <= wr_high_r;
        sensor_regs_pkg::OFS_WR_LOW: reg_rdata_out <= wr_low_r;
        sensor_regs_pkg::OFS_WR_CTRL: begin
          reg_rdata_out <= 16'h0000;
          reg_rdata_out[sensor_regs_pkg::BIT_BUSY] <= wr_busy_r;
          reg_rdata_out[sensor_regs_pkg::BIT_DONE] <= wr_done_r;
        end
        sensor_regs_pkg::OFS_RD_TARGET: reg_rdata_out <= {8'h00, rd_target_r};
        sensor_regs_pkg::OFS_RD_CTRL: begin
          reg_rdata_out <= 16'h0000;
          reg_rdata_out[sensor_regs_pkg::BIT_BUSY] <= rd_busy_r;
          reg_rdata_out[sensor_regs_pkg::BIT_DONE] <= rd_done_r;
        end
        sensor_regs_pkg::OFS_RD_HIGH: reg_rdata_out <= rd_word_r[31:16];
        sensor_regs_pkg::OFS_RD_LOW: reg_rdata_out <= rd_word_r[15:0];
        sensor_regs_pkg::OFS_ECHO: reg_rdata_out <= i2c_mode_in ? echo_value_r : 16'h0000;
        sensor_regs_pkg::OFS_FAST_XY:
          reg_rdata_out <= i2c_mode_in ? {res_r.axis_y_value[14:7], res_r.axis_x_value[14:7]} : 16'h0000;
        sensor_regs_pkg::OFS_FAST_TZ:
          reg_rdata_out <= i2c_mode_in ? {res_r.temp_value[11:4], res_r.axis_z_value[14:7]} : 16'h0000;
        sensor_regs_pkg::OFS_FAST_AM:
          reg_rdata_out <= i2c_mode_in ? {res_r.angle_value[14:7], res_r.magnitude_value[14:7]} : 16'h0000;
        sensor_regs_pkg::OFS_FAST_SC:
          reg_rdata_out <= i2c_mode_in ? {res_r.sine_value[14:7], res_r.cosine_value[14:7]} : 16'h0000;
        sensor_regs_pkg::OFS_TEMP: reg_rdata_out <= {4'h0, res_r.temp_value};
        sensor_regs_pkg::OFS_AXIS_X: reg_rdata_out <= pad15(res_r.axis_x_value);
        sensor_regs_pkg::OFS_AXIS_Y: reg_rdata_out <= pad15(res_r.axis_y_value);
        sensor_regs_pkg::OFS_AXIS_Z: reg_rdata_out <= pad15(res_r.axis_z_value);
        sensor_regs_pkg::OFS_ANGLE: reg_rdata_out <= pad15(res_r.angle_value);
        sensor_regs_pkg::OFS_MAG: reg_rdata_out <= pad15(res_r.magnitude_value);
        sensor_regs_pkg::OFS_SINE: reg_rdata_out <= pad15(res_r.sine_value);
        sensor_regs_pkg::OFS_COSINE: reg_rdata_out <= pad15(res_r.cosine_value);
        sensor_regs_pkg::OFS_RAW_X: reg_rdata_out <= pad15(res_r.axis_x_untrimmed_value);
        sensor_regs_pkg::OFS_RAW_Y: reg_rdata_out <= pad15(res_r.axis_y_untrimmed_value);
        sensor_regs_pkg::OFS_RAW_Z: reg_rdata_out <= pad15(res_r.axis_z_untrimmed_value);
        sensor_regs_pkg::OFS_ECHO_SEL: reg_rdata_out <= {8'h00, echo_select_r};
        default: reg_rdata_out <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

/* sensor_regs_pkg.sv */
// Purpose: Constants and carrier types for the direct register space.
// Assumes: Byte addresses are even; each register is one 16-bit word.
// Notes: Summary of operation below.
// Summary of operation
// - Writing one to launch bit 15 starts a write; sets busy, clears done, reads zero.
// - Write status bit 8 reads one while the extended write runs.
// - Write status bit 0 goes to one when the extended write finishes.
// - Writing one to launch bit 15 starts a read; sets busy, clears done, reads zero.
// - Read status bit 8 reads one while the extended read runs.
// - Read status bit 0 goes to one when read data is available.
// - Write word bytes come from the high and low data registers in order.
// - Read word splits into high register bits 31:16 and low register bits 15:0.
// - Extended target is the low eight bits; upper eight read as zero.
// - Echo register shows the channel the echo select held at the last result update.
// - Fast pack holds top eight bits of Y high, X low, Z low.
// - Top eight bits of temperature sit in the temperature and Z pack high byte.
// - Top eight bits of the angle sit in the angle pack high byte.
// - Top eight bits of the magnitude sit in the angle pack low byte.
// - Top eight bits of sine go high and cosine low in their pack.
// - Temperature is twelve signed bits, bits 15:12 read zero.
// - Each axis is fifteen signed bits, bit 15 reads zero.
// - Angle is an unsigned fifteen-bit code.
// - Squared field magnitude is a fifteen-bit value.
// - Sine and cosine inputs are fifteen signed bits, axes set by plane select.
// - Each axis also has an untrimmed fifteen-bit debug value.
// - Shadow locations sit 0x20 above their nonvolatile twins.
package sensor_regs_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  localparam logic [5:0] OFS_WR_TARGET = 6'h02;
  localparam logic [5:0] OFS_WR_HIGH = 6'h04;
  localparam logic [5:0] OFS_WR_LOW = 6'h06;
  localparam logic [5:0] OFS_WR_CTRL = 6'h08;
  localparam logic [5:0] OFS_RD_TARGET = 6'h0A;
  localparam logic [5:0] OFS_RD_CTRL = 6'h0C;
  localparam logic [5:0] OFS_RD_HIGH = 6'h0E;
  localparam logic [5:0] OFS_RD_LOW = 6'h10;
  localparam logic [5:0] OFS_ECHO = 6'h12;
  localparam logic [5:0] OFS_FAST_XY = 6'h14;
  localparam logic [5:0] OFS_FAST_TZ = 6'h16;
  localparam logic [5:0] OFS_FAST_AM = 6'h18;
  localparam logic [5:0] OFS_FAST_SC = 6'h1A;
  localparam logic [5:0] OFS_TEMP = 6'h1C;
  localparam logic [5:0] OFS_AXIS_X = 6'h1E;
  localparam logic [5:0] OFS_AXIS_Y = 6'h20;
  localparam logic [5:0] OFS_AXIS_Z = 6'h22;
  localparam logic [5:0] OFS_ANGLE = 6'h24;
  localparam logic [5:0] OFS_MAG = 6'h26;
  localparam logic [5:0] OFS_SINE = 6'h28;
  localparam logic [5:0] OFS_COSINE = 6'h2A;
  localparam logic [5:0] OFS_RAW_X = 6'h2C;
  localparam logic [5:0] OFS_RAW_Y = 6'h2E;
  localparam logic [5:0] OFS_RAW_Z = 6'h30;
  localparam logic [5:0] OFS_ECHO_SEL = 6'h34;

  // Status field positions
  localparam int BIT_LAUNCH = 15;
  localparam int BIT_BUSY = 8;
  localparam int BIT_DONE = 0;

  localparam logic [7:0] SHADOW_OFFSET = 8'h20;

  // Echo channel select codes
  localparam logic [7:0] ECHO_TEMP = 8'h00;
  localparam logic [7:0] ECHO_X = 8'h01;
  localparam logic [7:0] ECHO_Y = 8'h02;
  localparam logic [7:0] ECHO_Z = 8'h03;
  localparam logic [7:0] ECHO_ANGLE = 8'h04;
  localparam logic [7:0] ECHO_MAG = 8'h05;
  localparam logic [7:0] ECHO_SINE = 8'h06;
  localparam logic [7:0] ECHO_COSINE = 8'h07;

  typedef struct packed {
    logic [11:0] temp_value;
    logic [14:0] axis_x_value;
    logic [14:0] axis_y_value;
    logic [14:0] axis_z_value;
    logic [14:0] angle_value;
    logic [14:0] magnitude_value;
    logic [14:0] sine_value;
    logic [14:0] cosine_value;
    logic [14:0] axis_x_untrimmed_value;
    logic [14:0] axis_y_untrimmed_value;
    logic [14:0] axis_z_untrimmed_value;
  } sense_results_type;

  typedef struct packed {
    logic write;
    logic [7:0] target;
    logic [31:0] word;
  } ext_request_type;

endpackage

/* sensor_regs_sva.sv */
// Purpose: Port-level checks for the direct register space.
// Assumes: One clock, active-low asynchronous reset.
// Notes: Attached to every instance through the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module sensor_regs_sva (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [sensor_regs_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [1:0] reg_byte_en_in,
  input wire logic [sensor_regs_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic [sensor_regs_pkg::DATA_W-1:0] reg_rdata_out,
  // Mode and extended port
  input wire logic i2c_mode_in,
  input wire logic ext_req_out,
  input wire sensor_regs_pkg::ext_request_type ext_cmd_out,
  input wire logic ext_shadow_out,
  input wire logic ext_ack_in
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Launch only counts when the high lane carries bit 15
  wire launch = reg_wr_in && reg_byte_en_in[1] && reg_wdata_in[sensor_regs_pkg::BIT_LAUNCH];
  wire [5:0] adr = reg_addr_in;

  property p_wr_go; launch && adr == sensor_regs_pkg::OFS_WR_CTRL && !ext_req_out |=> ext_req_out && ext_cmd_out.write; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write launch did not start access");
  property p_rd_go; launch && adr == sensor_regs_pkg::OFS_RD_CTRL && !ext_req_out |=> ext_req_out && !ext_cmd_out.write; endproperty
  a_rd_go: assert property (p_rd_go) else $error("read launch did not start access");
  property p_hold; ext_req_out && !ext_ack_in |=> ext_req_out && $stable(ext_cmd_out); endproperty
  a_hold: assert property (p_hold) else $error("access dropped or changed before ack");
  property p_finish; ext_req_out && ext_ack_in |=> !ext_req_out; endproperty
  a_finish: assert property (p_finish) else $error("access stayed open after ack");
  property p_shadow; ext_req_out |-> ext_shadow_out == (ext_cmd_out.target >= sensor_regs_pkg::SHADOW_OFFSET); endproperty
  a_shadow: assert property (p_shadow) else $error("shadow flag wrong for target");
  property p_wr_busy;
    reg_rd_in && adr == sensor_regs_pkg::OFS_WR_CTRL && ext_req_out && ext_cmd_out.write && !ext_ack_in
    |=> reg_rdata_out == 16'h0100;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write status wrong while busy");
  property p_rd_busy;
    reg_rd_in && adr == sensor_regs_pkg::OFS_RD_CTRL && ext_req_out && !ext_cmd_out.write && !ext_ack_in
    |=> reg_rdata_out == 16'h0100;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read status wrong while busy");
  property p_msb; reg_rd_in && adr >= sensor_regs_pkg::OFS_AXIS_X && adr <= sensor_regs_pkg::OFS_RAW_Z ##1 1'b1 |-> !reg_rdata_out[15]; endproperty
  a_msb: assert property (p_msb) else $error("result bit 15 not zero");
  property p_spi; reg_rd_in && !i2c_mode_in && adr >= sensor_regs_pkg::OFS_ECHO && adr <= sensor_regs_pkg::OFS_FAST_SC |=> reg_rdata_out == 16'h0000; endproperty
  a_spi: assert property (p_spi) else $error("fast register not blank in SPI mode");
endmodule
bind sensor_direct_register_space sensor_regs_sva i_sensor_regs_sva (.clock_in(clock_in), .rst_b_in(rst_b_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_byte_en_in(reg_byte_en_in), .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .i2c_mode_in(i2c_mode_in), .ext_req_out(ext_req_out),
  .ext_cmd_out(ext_cmd_out), .ext_shadow_out(ext_shadow_out), .ext_ack_in(ext_ack_in));
`default_nettype wire

/* testbench.sv */
// Purpose: Register-level test of the direct register space.
// Assumes: Strobe port with read data one cycle after the read edge.
// Notes: Echo of temperature is expected as the zero-extended register view.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [5:0] reg_addr_in = 6'h00;
  logic reg_wr_in = 1'b0;
  logic [1:0] reg_byte_en_in = 2'b00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic i2c_mode_in = 1'b1;
  logic results_update_in = 1'b0;
  sensor_regs_pkg::sense_results_type results_in = '0;
  sensor_regs_pkg::sense_results_type r;
  sensor_regs_pkg::ext_request_type ext_cmd_out;
  logic ext_req_out, ext_shadow_out, ext_ack_in;
  logic [31:0] ext_rdata_in;
  logic [3:0] delay = 4'h5;
  logic [15:0] got;
  int errors = 0;
  int n_compared = 0;

  always #20 clock_in = ~clock_in;

  sensor_direct_register_space i_sensor_direct_register_space (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_byte_en_in(reg_byte_en_in), .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .i2c_mode_in(i2c_mode_in),
    .results_update_in(results_update_in), .results_in(results_in), .ext_req_out(ext_req_out),
    .ext_cmd_out(ext_cmd_out), .ext_shadow_out(ext_shadow_out), .ext_ack_in(ext_ack_in), .ext_rdata_in(ext_rdata_in));
  ext_mem_model i_ext_mem_model (.clock_in(clock_in), .rst_b_in(rst_b_in), .req_in(ext_req_out), .cmd_in(ext_cmd_out),
    .delay_in(delay), .ack_out(ext_ack_in), .rdata_out(ext_rdata_in));

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_byte_en_in <= be;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 got = reg_rdata_out;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    rd(a);
    chk({16'h0000, got}, {16'h0000, e});
  endtask
  // Done polling; a stuck mailbox counts as a mismatch and ends the run
  task automatic poll(input logic [5:0] a);
    for (int i = 0; i < 40; i++) begin
      rd(a);
      if (got[0] === 1'b1) begin
        chk({16'h0000, got}, 32'h0000_0001);
        return;
      end
    end
    errors++;
    $display("mismatch at %0t got %h expected %h", $time, got, 16'h0001);
    complete_run();
  endtask
  task automatic refresh();
    @(posedge clock_in);
    results_in <= r;
    results_update_in <= 1'b1;
    @(posedge clock_in);
    results_update_in <= 1'b0;
  endtask
  task automatic ext_access(input logic [5:0] ctl, input logic [5:0] tgt, input logic [15:0] t);
    wr(tgt, 2'b11, 16'hFF00 | t);
    rchk(tgt, t);
    wr(ctl, 2'b10, 16'h8000);
    if (delay != 4'h0) rchk(ctl, 16'h0100);
    poll(ctl);
  endtask

  initial begin
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rchk(sensor_regs_pkg::OFS_WR_CTRL, 16'h0000);
    wr(sensor_regs_pkg::OFS_WR_HIGH, 2'b11, 16'h1234);
    wr(sensor_regs_pkg::OFS_WR_LOW, 2'b11, 16'h5678);
    ext_access(sensor_regs_pkg::OFS_WR_CTRL, sensor_regs_pkg::OFS_WR_TARGET, 16'h0025);
    chk(i_ext_mem_model.mem[8'h25], 32'h1234_5678);
    chk({31'h0, ext_shadow_out}, 32'h0000_0001);
    ext_access(sensor_regs_pkg::OFS_RD_CTRL, sensor_regs_pkg::OFS_RD_TARGET, 16'h0025);
    rchk(sensor_regs_pkg::OFS_RD_HIGH, 16'h1234);
    rchk(sensor_regs_pkg::OFS_RD_LOW, 16'h5678);
    @(posedge clock_in) delay <= 4'h0;
    ext_access(sensor_regs_pkg::OFS_RD_CTRL, sensor_regs_pkg::OFS_RD_TARGET, 16'h0007);
    rchk(sensor_regs_pkg::OFS_RD_HIGH, 16'hC35A);
    rchk(sensor_regs_pkg::OFS_RD_LOW, 16'h07F8);
    chk({31'h0, ext_shadow_out}, 32'h0000_0000);
    r = {12'hA5C, 15'h4A3C, 15'h2B71, 15'h7F01, 15'h6D2E, 15'h1C88, 15'h5E09, 15'h0F7A, 15'h3333, 15'h4CC4,
      15'h7AB5};
    refresh();
    rchk(sensor_regs_pkg::OFS_TEMP, {4'h0, r.temp_value});
    for (int i = 0; i < 10; i++)
      rchk(sensor_regs_pkg::OFS_AXIS_X + 6'(2 * i), {1'b0, r[149 - 15 * i -: 15]});
    rchk(sensor_regs_pkg::OFS_FAST_XY, {r.axis_y_value[14:7], r.axis_x_value[14:7]});
    rchk(sensor_regs_pkg::OFS_FAST_TZ, {r.temp_value[11:4], r.axis_z_value[14:7]});
    rchk(sensor_regs_pkg::OFS_FAST_AM, {r.angle_value[14:7], r.magnitude_value[14:7]});
    rchk(sensor_regs_pkg::OFS_FAST_SC, {r.sine_value[14:7], r.cosine_value[14:7]});
    for (int c = 0; c < 9; c++) begin
      wr(sensor_regs_pkg::OFS_ECHO_SEL, 2'b01, 16'(c));
      refresh();
      rchk(sensor_regs_pkg::OFS_ECHO, c == 0 ? {4'h0, r.temp_value} : c > 7 ? 16'h0000 : {1'b0, r[164 - 15 * c -: 15]});
    end
    @(posedge clock_in) i2c_mode_in <= 1'b0;
    rchk(sensor_regs_pkg::OFS_FAST_XY, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
